// file: rtl/ssrp_map.vh
// Constants for the service request port: command codes, AHB codes, sizes, addresses.
// Assumes inclusion by the single design module only.
`ifndef SSRP_MAP_VH
`define SSRP_MAP_VH
`define SSRP_CMD_CERT 8'h00
`define SSRP_CMD_SERIAL 8'h01
`define SSRP_CMD_USER_ID_CODE 8'h04
`define SSRP_CMD_VERSION 8'h05
`define SSRP_STAT_OK 8'h00
`define SSRP_STAT_UNKNOWN 8'hFC
`define SSRP_STAT_BUSERR 8'hFF
`define SSRP_PAD24 24'h000000
`define SSRP_WORDS_SERIAL 10'h004
`define SSRP_WORDS_USER_ID_CODE 10'h001
`define SSRP_WORDS_CERT 10'h0C0
`define SSRP_WORDS_VERSION 10'h001
`define SSRP_WORDS_ZERO 10'h000
`define SSRP_WORDS_ONE 10'h001
`define SSRP_HTRANS_IDLE 2'h0
`define SSRP_HTRANS_NONSEQ 2'h2
`define SSRP_HSIZE_WORD 3'h2
`define SSRP_HBURST_SINGLE 3'h0
`define SSRP_ADDR_CTRL 32'h40016000
`define SSRP_ADDR_STATUS 32'h40016004
`define SSRP_ADDR_DATA 32'h4001600C
`define SSRP_ADDR_STEP 32'h00000004
`define SSRP_BIT_RXAVAIL 1
`endif

// file: rtl/ssrp_top.v
// Service request front end: user command port in, AHB-Lite master out toward the communication block.
// Assumes an AHB-Lite fabric port on clk with a single slave behind it.
// Function
// - Decode each command code and turn each of the four known codes into AHB-Lite master transfers.
// - service_in_progress low when idle, high throughout a service.
// - Results return as 32-bit read_word qualified by read_word_valid.
// - One 8-bit response_code per service qualified by response_code_valid.
// - Codes: serial 1, user code 4, certificate 0, design version 5.
// - comm_block_interrupt input from the block gates the result reads once result words are ready.
// - Unknown code answers with the echoed command and status 252.
`timescale 1ns/100ps
`include "ssrp_map.vh"
module ssrp_top (
   input wire clk,
   input wire rst,
   input wire request_strobe,
   input wire [7:0] command_code_in,
   output wire service_in_progress,
   output reg [31:0] read_word,
   output reg read_word_valid,
   output reg [7:0] response_code,
   output reg response_code_valid,
   input wire comm_block_interrupt,
   output reg [31:0] haddr,
   output reg [1:0] htrans,
   output reg hwrite,
   output wire [2:0] hsize,
   output wire [2:0] hburst,
   output reg [31:0] hwdata,
   input wire [31:0] hrdata,
   input wire hready,
   input wire hresp
);
   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer states
   localparam ST_IDLE = 3'h0;
   localparam ST_CMD_A = 3'h1;
   localparam ST_CMD_D = 3'h2;
   localparam ST_WAIT = 3'h3;
   localparam ST_RD_A = 3'h4;
   localparam ST_RD_D = 3'h5;
   localparam ST_DONE = 3'h6;

   ////////////////////////////////////////////////////////////////////////////////
   // Request and transfer bookkeeping
   reg [2:0] state_reg;
   reg [7:0] cmd_reg;
   reg [9:0] left_reg;
   reg [31:0] rd_addr_reg;
   reg err_reg;
   reg strobe_seen_reg;

   // Interrupt synchroniser stages and the agreed level
   reg [2:0] irq_sync_reg;
   reg irq_level_reg;

   // Word count for the code now on the input
   reg [9:0] words_next;
   wire irq_event;
   wire take_req;

   ////////////////////////////////////////////////////////////////////////////////
   // Word singles only; no bursts, so every stalled word costs its own wait
   assign hsize = `SSRP_HSIZE_WORD;
   assign hburst = `SSRP_HBURST_SINGLE;
   assign service_in_progress = (state_reg != ST_IDLE);

   // Rising strobe only, so a held strobe does not relaunch the service
   assign take_req = request_strobe && !strobe_seen_reg;

   // Agreed interrupt level gates the result reads
   assign irq_event = irq_level_reg;
   ////////////////////////////////////////////////////////////////////////////////
   // Fixed result sizes in words: serial 4, user code 1, certificate 192, version 1
   always @* begin
      case (command_code_in)
         `SSRP_CMD_SERIAL: words_next = `SSRP_WORDS_SERIAL;
         `SSRP_CMD_USER_ID_CODE: words_next = `SSRP_WORDS_USER_ID_CODE;
         `SSRP_CMD_CERT: words_next = `SSRP_WORDS_CERT;
         `SSRP_CMD_VERSION: words_next = `SSRP_WORDS_VERSION;
         default: words_next = `SSRP_WORDS_ZERO;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt is from the controller's domain; a change counts once stages two and three agree
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_sync_reg <= 3'h0;
         irq_level_reg <= 1'b0;
      end else begin
         irq_sync_reg <= {irq_sync_reg[1:0], comm_block_interrupt};
         if (irq_sync_reg[1] == irq_sync_reg[2]) begin
            irq_level_reg <= irq_sync_reg[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequencer: command write, interrupt wait, word reads, status
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         cmd_reg <= 8'h00;
         left_reg <= 10'h000;
         rd_addr_reg <= 32'h00000000;
         err_reg <= 1'b0;
         strobe_seen_reg <= 1'b0;
         haddr <= 32'h00000000;
         htrans <= `SSRP_HTRANS_IDLE;
         hwrite <= 1'b0;
         hwdata <= 32'h00000000;
         read_word <= 32'h00000000;
         read_word_valid <= 1'b0;
         response_code <= 8'h00;
         response_code_valid <= 1'b0;
      end else begin
         // Pulses default low and stand for the single cycle that sets them
         read_word_valid <= 1'b0;
         response_code_valid <= 1'b0;
         strobe_seen_reg <= request_strobe;
         case (state_reg)
            // Waiting for a fresh request
            ST_IDLE: begin
               if (take_req) begin
                  cmd_reg <= command_code_in;
                  left_reg <= words_next;
                  err_reg <= 1'b0;
                  rd_addr_reg <= `SSRP_ADDR_DATA;
                  if (words_next == `SSRP_WORDS_ZERO) begin
                     state_reg <= ST_DONE;
                  end else begin
                     haddr <= `SSRP_ADDR_CTRL;
                     htrans <= `SSRP_HTRANS_NONSEQ;
                     hwrite <= 1'b1;
                     state_reg <= ST_CMD_A;
                  end
               end
            end

            // Address phase of the command write
            ST_CMD_A: begin
               if (hready) begin
                  htrans <= `SSRP_HTRANS_IDLE;
                  hwrite <= 1'b0;
                  hwdata <= {`SSRP_PAD24, cmd_reg};
                  state_reg <= ST_CMD_D;
               end
            end

            // Data phase carries the command byte
            ST_CMD_D: begin
               if (hready) begin
                  err_reg <= hresp;
                  state_reg <= hresp ? ST_DONE : ST_WAIT;
               end
            end

            ST_WAIT: begin
               // Controller raises its interrupt when result words are ready
               if (irq_event) begin
                  haddr <= rd_addr_reg;
                  htrans <= `SSRP_HTRANS_NONSEQ;
                  state_reg <= ST_RD_A;
               end
            end

            // Address phase of one result read
            ST_RD_A: begin
               if (hready) begin
                  htrans <= `SSRP_HTRANS_IDLE;
                  state_reg <= ST_RD_D;
               end
            end

            // Data phase; one word out per read
            ST_RD_D: begin
               if (hready) begin
                  read_word <= hrdata;
                  read_word_valid <= ~hresp;
                  err_reg <= hresp;
                  left_reg <= left_reg - `SSRP_WORDS_ONE;
                  rd_addr_reg <= rd_addr_reg + `SSRP_ADDR_STEP;
                  if (hresp || left_reg == `SSRP_WORDS_ONE) begin
                     state_reg <= ST_DONE;
                  end else begin
                     haddr <= rd_addr_reg + `SSRP_ADDR_STEP;
                     htrans <= `SSRP_HTRANS_NONSEQ;
                     state_reg <= ST_RD_A;
                  end
               end
            end

            // One status per service, then back to idle
            ST_DONE: begin
               response_code_valid <= 1'b1;
               if (left_reg == `SSRP_WORDS_ZERO && !err_reg && words_ok(cmd_reg)) begin
                  response_code <= `SSRP_STAT_OK;
               end else if (!words_ok(cmd_reg)) begin
                  // Echo of the command rides on read_word in the same cycle
                  response_code <= `SSRP_STAT_UNKNOWN;
                  read_word <= {`SSRP_PAD24, cmd_reg};
               end else begin
                  response_code <= `SSRP_STAT_BUSERR;
               end
               state_reg <= ST_IDLE;
            end

            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // True for the four device information codes
   function words_ok;
      input [7:0] code;
      begin
         words_ok = (code == `SSRP_CMD_SERIAL) ||
            (code == `SSRP_CMD_USER_ID_CODE) ||
            (code == `SSRP_CMD_CERT) ||
            (code == `SSRP_CMD_VERSION);
      end
   endfunction
endmodule // ssrp_top

// file: dv/ssrp_props.sv
// Pin assertions for the service request port.
// Assumes bind onto ssrp_top; one clock, async reset.
`timescale 1ns/100ps
module ssrp_props (
   input wire clk,
   input wire rst,
   input wire request_strobe,
   input wire [7:0] command_code_in,
   input wire service_in_progress,
   input wire read_word_valid,
   input wire [7:0] response_code,
   input wire response_code_valid,
   input wire comm_block_interrupt,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite
);
   wire known = command_code_in inside {8'h00, 8'h01, 8'h04, 8'h05};
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence take_s;
      $rose(request_strobe) && !service_in_progress;
   endsequence
   busy_rise_a: assert property (take_s |=> service_in_progress) else $error("busy late");
   unknown_reply_a: assert property (take_s ##0 !known |-> ##2 response_code_valid && response_code == 8'hFC)
      else $error("bad unknown reply");
   bus_start_a: assert property (take_s ##0 known |=> htrans == 2'h2 && hwrite) else $error("no write");
   cmd_addr_a: assert property (take_s ##0 known |=> haddr == 32'h40016000) else $error("bad command address");
   known_wait_a: assert property (take_s ##0 known |-> (!response_code_valid)[*4]) else $error("early");
   busy_fall_a: assert property (response_code_valid |=> !service_in_progress) else $error("busy stuck");
   idle_quiet_a: assert property (!service_in_progress |-> !read_word_valid && htrans == 2'h0)
      else $error("idle activity");
   irq_gate_a: assert property ((!comm_block_interrupt)[*5] |=> !(htrans == 2'h2 && !hwrite))
      else $error("ungated read");
   word_gap_a: assert property (read_word_valid |=> !read_word_valid) else $error("valid held");
endmodule // ssrp_props
bind ssrp_top ssrp_props i_props (.*);

// file: dv/ssrp_comm_model.sv
// Communication block stand-in: AHB-Lite slave, random stalls.
// Assumes word transfers; interrupt rises after first transfer.
`timescale 1ns/100ps
module ssrp_comm_model (
   input wire clk,
   input wire rst,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   output wire [31:0] hrdata,
   output wire hready,
   output reg comm_block_interrupt
);
   reg dp_reg;
   reg go_reg;
   reg [31:0] addr_reg;
   assign hready = !dp_reg || go_reg;
   // Outside a finished data phase the bus shows junk
   assign hrdata = dp_reg && go_reg ? addr_reg ^ 32'h5A5A0000 : ~addr_reg;
   always @(posedge clk) begin
      go_reg <= $urandom_range(1);
      dp_reg <= !rst && (hready ? htrans == 2'h2 : dp_reg);
      addr_reg <= hready ? haddr : addr_reg;
      comm_block_interrupt <= !rst && (comm_block_interrupt || dp_reg);
   end
endmodule // ssrp_comm_model

// file: dv/ssrp_tb.sv
// Self-checking bench for the service request port.
// Assumes ssrp_top and ssrp_comm_model.
`timescale 1ns/100ps
module system_service_request_port_tb;
   logic clk = 1'b0, rst = 1'b1, request_strobe = 1'b0;
   logic [7:0] command_code_in = 8'h00, c;
   wire service_in_progress, read_word_valid, response_code_valid, hwrite, hready, comm_block_interrupt;
   wire [31:0] read_word, haddr, hwdata, hrdata;
   wire [7:0] response_code;
   wire [1:0] htrans;
   int mismatches = 0, checks_done = 0, i, k;
   logic [31:0] wq[$];
   logic [31:0] eq[$];
   logic [7:0] e;
   logic [7:0] rq[$];
   logic [7:0] codes[4] = '{8'h00, 8'h01, 8'h04, 8'h05};
   int words[4] = '{192, 4, 1, 1};
   always #20 clk = ~clk;
   ssrp_top i_dut (.*, .hsize(), .hburst(), .hresp(1'b0));
   ssrp_comm_model i_model (.*);
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task print_verdict;
      if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      if (read_word_valid) check("word", read_word, wq.size() ? wq.pop_front() : 'x);
      if (response_code_valid) begin
         e = rq.size() ? rq.pop_front() : 'x;
         check("resp", {24'h0, response_code}, e);
         if (e === 8'hFC) check("echo", read_word, eq.size() ? eq.pop_front() : 'x);
      end
   end
   task serve(int n);
      for (k = 0; k < n; k++) wq.push_back((32'h4001600C + 4 * k) ^ 32'h5A5A0000);
      rq.push_back(n ? 8'h00 : 8'hFC);
      if (!n) eq.push_back({24'h0, c});
      request_strobe <= 1'b1;
      command_code_in <= c;
      k = 0;
      do @(negedge clk); while (!service_in_progress && ++k < 300);
      @(posedge clk) request_strobe <= 1'b0;
      // Second rising edge while busy must be ignored
      if (n) @(posedge clk) request_strobe <= 1'b1;
      if (n) @(posedge clk) request_strobe <= 1'b0;
      k = 0;
      do @(negedge clk); while (service_in_progress && ++k < 5000);
      check("busy", {31'h0, service_in_progress}, 32'h0);
      @(posedge clk);
   endtask
   initial begin
      i = $urandom(32'h657BCCB2);
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 12; i++) begin
         c = i < 8 ? codes[i[2:1]] : 8'($urandom);
         if (i >= 8 && c inside {codes}) c = c ^ 8'h02;
         serve(i < 8 ? words[i[2:1]] : 0);
      end
      print_verdict;
   end
   initial begin
      #(40 * 30000);
      mismatches++;
      print_verdict;
   end
endmodule // system_service_request_port_tb
